// >>> verilog/rpsel_defs.svh
// Register offsets, field positions, reset values and sizes of the pin select
`ifndef RPSEL_DEFS_SVH
`define RPSEL_DEFS_SVH
`define RPSEL_ADDR_W 6
`define RPSEL_SEL_W 5
`define RPSEL_NUM_PINS 26
`define RPSEL_NUM_IN_FUNCS 14
`define RPSEL_NUM_OUT_FUNCS 31
`define RPSEL_IN_REGS 7
`define RPSEL_OUT_REGS 13
`define RPSEL_IN_BASE 6'h00
`define RPSEL_OUT_BASE 6'h10
`define RPSEL_LO_FIELD_LSB 0
`define RPSEL_HI_FIELD_LSB 8
`define RPSEL_FIELD_MASK 16'h1F1F
`define RPSEL_IN_RESET 16'h0000
`define RPSEL_CAP78_RESET 16'h1F1F
`define RPSEL_CAP78_IDX 3
`define RPSEL_OUT_RESET 16'h0000
`define RPSEL_SEL_TIE_LOW 5'h1F
`define RPSEL_SEL_NULL 5'h00
`endif

// >>> verilog/rpsel_pkg.sv
// Types shared by the pin select crossbar
package rpsel_pkg;
	// Register access request from software
	typedef struct packed {
		logic [5:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} rpsel_req_t;
	// Routed peripheral inputs, one bit each
	typedef struct packed {
		logic ext_irq_one_in;
		logic ext_irq_two_in;
		logic timer_two_ext_clk;
		logic timer_three_ext_clk;
		logic capture_one_in;
		logic capture_two_in;
		logic capture_seven_in;
		logic capture_eight_in;
		logic compare_fault_a_in;
		logic uart_one_rx_in;
		logic uart_one_cts_in;
		logic spi_one_data_in;
		logic spi_one_clock_in;
		logic spi_one_select_in;
	} rpsel_func_in_t;
endpackage

// >>> verilog/rpsel_top.sv
// Peripheral pin select crossbar with its routing registers
// Operation
// - Each of the two external interrupt inputs takes its pin from its own 5-bit field.
// - The timer 2 and timer 3 external clocks take their pins from separate 5-bit fields.
// - The output compare fault A input takes its pin from its own 5-bit field.
// - UART 1 receive and clear-to-send take their pins from two independent fields.
// - SPI 1 data, clock and select inputs take their pins from three independent fields.
// - Every remappable pin has its own 5-bit output field, two per output register.
// - A pin is driven by the peripheral output whose code equals its field.
// - Output code zero leaves the pin connected to no peripheral output.
`timescale 1ns/1ps
`include "rpsel_defs.svh"
module rpsel_top #(
	parameter int NUM_PINS = `RPSEL_NUM_PINS,
	parameter int NUM_OUT_FUNCS = `RPSEL_NUM_OUT_FUNCS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire rpsel_pkg::rpsel_req_t bus_req,
	output logic [15:0] bus_rdata,
	// Package pins; inputs asynchronous, outputs registered on sys_clk
	input wire logic [NUM_PINS-1:0] remap_pin_n_in,
	output logic [NUM_PINS-1:0] remap_pin_n_out,
	output logic [NUM_PINS-1:0] remap_pin_n_drive,
	// Peripheral side; output function code k sits at bit k-1
	output rpsel_pkg::rpsel_func_in_t func_in,
	input wire logic [NUM_OUT_FUNCS-1:0] periph_out
);

	localparam int NIN = `RPSEL_NUM_IN_FUNCS;
	localparam int NIR = `RPSEL_IN_REGS;
	localparam int NOR = `RPSEL_OUT_REGS;
	localparam int SW = `RPSEL_SEL_W;

	// Routing registers
	logic [15:0] in_regs_r [NIR];
	logic [15:0] in_regs_nxt [NIR];
	logic [15:0] out_regs_r [NOR];
	logic [15:0] out_regs_nxt [NOR];
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	// Address decode, one hit line per register
	logic [NIR-1:0] in_hit;
	logic [NOR-1:0] out_hit;
	// Pin synchronisers; stage one is read only by stage two
	logic [NUM_PINS-1:0] pin_s1_r;
	logic [NUM_PINS-1:0] pin_s2_r;
	// Routed values
	rpsel_pkg::rpsel_func_in_t func_r;
	rpsel_pkg::rpsel_func_in_t func_nxt;
	logic [NUM_PINS-1:0] pout_r;
	logic [NUM_PINS-1:0] pout_nxt;
	logic [NUM_PINS-1:0] pdrv_r;
	logic [NUM_PINS-1:0] pdrv_nxt;
	logic [SW-1:0] in_sel [NIN];
	logic [SW-1:0] out_sel [NUM_PINS];

	// Pin pick for one input function; codes past the last pin tie low
	function automatic logic route_pin(input logic [SW-1:0] sel,
		input logic [NUM_PINS-1:0] pins);
		logic v;
		v = 1'b0;
		if (int'(sel) < NUM_PINS)
			v = pins[sel];
		return v;
	endfunction

	// Address decode; holes in the map hit nothing
	always_comb begin
		in_hit = '0;
		out_hit = '0;
		case (bus_req.addr)
			`RPSEL_IN_BASE + 6'h00: in_hit[0] = 1'b1;
			`RPSEL_IN_BASE + 6'h01: in_hit[1] = 1'b1;
			`RPSEL_IN_BASE + 6'h02: in_hit[2] = 1'b1;
			`RPSEL_IN_BASE + 6'h03: in_hit[3] = 1'b1;
			`RPSEL_IN_BASE + 6'h04: in_hit[4] = 1'b1;
			`RPSEL_IN_BASE + 6'h05: in_hit[5] = 1'b1;
			`RPSEL_IN_BASE + 6'h06: in_hit[6] = 1'b1;
			`RPSEL_OUT_BASE + 6'h00: out_hit[0] = 1'b1;
			`RPSEL_OUT_BASE + 6'h01: out_hit[1] = 1'b1;
			`RPSEL_OUT_BASE + 6'h02: out_hit[2] = 1'b1;
			`RPSEL_OUT_BASE + 6'h03: out_hit[3] = 1'b1;
			`RPSEL_OUT_BASE + 6'h04: out_hit[4] = 1'b1;
			`RPSEL_OUT_BASE + 6'h05: out_hit[5] = 1'b1;
			`RPSEL_OUT_BASE + 6'h06: out_hit[6] = 1'b1;
			`RPSEL_OUT_BASE + 6'h07: out_hit[7] = 1'b1;
			`RPSEL_OUT_BASE + 6'h08: out_hit[8] = 1'b1;
			`RPSEL_OUT_BASE + 6'h09: out_hit[9] = 1'b1;
			`RPSEL_OUT_BASE + 6'h0A: out_hit[10] = 1'b1;
			`RPSEL_OUT_BASE + 6'h0B: out_hit[11] = 1'b1;
			`RPSEL_OUT_BASE + 6'h0C: out_hit[12] = 1'b1;
			default: begin
				in_hit = '0;
				out_hit = '0;
			end
		endcase
	end

	// Register writes; unimplemented bits never reach the flops
	always_comb begin
		for (int i = 0; i < NIR; i++) begin
			in_regs_nxt[i] = in_regs_r[i];
			if (bus_req.wr && in_hit[i])
				in_regs_nxt[i] = bus_req.wdata & `RPSEL_FIELD_MASK;
		end
		for (int i = 0; i < NOR; i++) begin
			out_regs_nxt[i] = out_regs_r[i];
			if (bus_req.wr && out_hit[i])
				out_regs_nxt[i] = bus_req.wdata & `RPSEL_FIELD_MASK;
		end
	end

	// Read mux; an idle cycle or a hole returns zero
	always_comb begin
		rdata_nxt = 16'h0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`RPSEL_IN_BASE + 6'h00: rdata_nxt = in_regs_r[0];
				`RPSEL_IN_BASE + 6'h01: rdata_nxt = in_regs_r[1];
				`RPSEL_IN_BASE + 6'h02: rdata_nxt = in_regs_r[2];
				`RPSEL_IN_BASE + 6'h03: rdata_nxt = in_regs_r[3];
				`RPSEL_IN_BASE + 6'h04: rdata_nxt = in_regs_r[4];
				`RPSEL_IN_BASE + 6'h05: rdata_nxt = in_regs_r[5];
				`RPSEL_IN_BASE + 6'h06: rdata_nxt = in_regs_r[6];
				`RPSEL_OUT_BASE + 6'h00: rdata_nxt = out_regs_r[0];
				`RPSEL_OUT_BASE + 6'h01: rdata_nxt = out_regs_r[1];
				`RPSEL_OUT_BASE + 6'h02: rdata_nxt = out_regs_r[2];
				`RPSEL_OUT_BASE + 6'h03: rdata_nxt = out_regs_r[3];
				`RPSEL_OUT_BASE + 6'h04: rdata_nxt = out_regs_r[4];
				`RPSEL_OUT_BASE + 6'h05: rdata_nxt = out_regs_r[5];
				`RPSEL_OUT_BASE + 6'h06: rdata_nxt = out_regs_r[6];
				`RPSEL_OUT_BASE + 6'h07: rdata_nxt = out_regs_r[7];
				`RPSEL_OUT_BASE + 6'h08: rdata_nxt = out_regs_r[8];
				`RPSEL_OUT_BASE + 6'h09: rdata_nxt = out_regs_r[9];
				`RPSEL_OUT_BASE + 6'h0A: rdata_nxt = out_regs_r[10];
				`RPSEL_OUT_BASE + 6'h0B: rdata_nxt = out_regs_r[11];
				`RPSEL_OUT_BASE + 6'h0C: rdata_nxt = out_regs_r[12];
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	// Register storage; capture 7/8 fields come up tied low
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NIR; i++)
				in_regs_r[i] <= (i == `RPSEL_CAP78_IDX) ?
					`RPSEL_CAP78_RESET : `RPSEL_IN_RESET;
			for (int i = 0; i < NOR; i++)
				out_regs_r[i] <= `RPSEL_OUT_RESET;
			rdata_r <= 16'h0000;
		end else begin
			in_regs_r <= in_regs_nxt;
			out_regs_r <= out_regs_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Field extraction: two fields per register, low then high
	always_comb begin
		for (int f = 0; f < NIN; f++)
			in_sel[f] = (f % 2 == 0) ?
				in_regs_r[f/2][`RPSEL_LO_FIELD_LSB +: SW] :
				in_regs_r[f/2][`RPSEL_HI_FIELD_LSB +: SW];
		for (int p = 0; p < NUM_PINS; p++)
			out_sel[p] = (p % 2 == 0) ?
				out_regs_r[p/2][`RPSEL_LO_FIELD_LSB +: SW] :
				out_regs_r[p/2][`RPSEL_HI_FIELD_LSB +: SW];
	end

	// Input crossbar by function name, so a slot mix-up is easy to spot
	always_comb begin
		func_nxt.ext_irq_one_in = route_pin(in_sel[0], pin_s2_r);
		func_nxt.ext_irq_two_in = route_pin(in_sel[1], pin_s2_r);
		func_nxt.timer_two_ext_clk = route_pin(in_sel[2], pin_s2_r);
		func_nxt.timer_three_ext_clk = route_pin(in_sel[3], pin_s2_r);
		func_nxt.capture_one_in = route_pin(in_sel[4], pin_s2_r);
		func_nxt.capture_two_in = route_pin(in_sel[5], pin_s2_r);
		func_nxt.capture_seven_in = route_pin(in_sel[6], pin_s2_r);
		func_nxt.capture_eight_in = route_pin(in_sel[7], pin_s2_r);
		func_nxt.compare_fault_a_in = route_pin(in_sel[8], pin_s2_r);
		func_nxt.uart_one_rx_in = route_pin(in_sel[9], pin_s2_r);
		func_nxt.uart_one_cts_in = route_pin(in_sel[10], pin_s2_r);
		func_nxt.spi_one_data_in = route_pin(in_sel[11], pin_s2_r);
		func_nxt.spi_one_clock_in = route_pin(in_sel[12], pin_s2_r);
		func_nxt.spi_one_select_in = route_pin(in_sel[13], pin_s2_r);
	end

	// Output crossbar: each pin picks one peripheral output
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			pout_nxt[p] = 1'b0;
			pdrv_nxt[p] = 1'b1; // High enable means not driven
			if (out_sel[p] != `RPSEL_SEL_NULL &&
				int'(out_sel[p]) <= NUM_OUT_FUNCS) begin
				pout_nxt[p] = periph_out[out_sel[p] - 5'h01];
				pdrv_nxt[p] = 1'b0;
			end
		end
	end

	// Synchronisers and registered routing outputs
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			func_r <= '0;
			pout_r <= '0;
			pdrv_r <= '1;
		end else begin
			pin_s1_r <= remap_pin_n_in;
			pin_s2_r <= pin_s1_r;
			func_r <= func_nxt;
			pout_r <= pout_nxt;
			pdrv_r <= pdrv_nxt;
		end
	end

	assign bus_rdata = rdata_r;
	assign func_in = func_r;
	assign remap_pin_n_out = pout_r;
	assign remap_pin_n_drive = pdrv_r;
endmodule

// >>> tb/rpsel_periph.sv
// Peripheral output model for the pin select bench
`timescale 1ns/1ps
module rpsel_periph (
	// Clock and freeze
	input wire logic sys_clk,
	input wire logic hold,
	// Outputs of function codes 1 to 31
	output logic [30:0] periph_out
);
	// Fresh pattern each cycle while hold is low so a wrong pick shows
	initial periph_out = 31'h0;
	always @(posedge sys_clk) if (!hold) periph_out <= 31'($urandom);
endmodule

// >>> tb/rpsel_top_assertions.sv
// Port checker for the pin select crossbar
`timescale 1ns/1ps
module rpsel_chk #(parameter int NUM_PINS = 26,
	parameter int NUM_OUT_FUNCS = 31) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire rpsel_pkg::rpsel_req_t bus_req,
	input wire logic [15:0] bus_rdata,
	// Pins and peripherals
	input wire logic [NUM_PINS-1:0] remap_pin_n_in,
	input wire logic [NUM_PINS-1:0] remap_pin_n_out,
	input wire logic [NUM_PINS-1:0] remap_pin_n_drive,
	input wire rpsel_pkg::rpsel_func_in_t func_in,
	input wire logic [NUM_OUT_FUNCS-1:0] periph_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Pin 0 field written with a code
	sequence s_pin0(code);
		$past(bus_req.wr) && $past(bus_req.addr) == 6'h10 &&
			$past(bus_req.wdata[4:0]) == code;
	endsequence
	a_rd_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0)
		else $error("data out of slot");
	a_rd_gaps: assert property (
		$past(bus_req.rd) |-> (bus_rdata & 16'hE0E0) == 16'h0)
		else $error("unused bits set");
	a_rd_unmap: assert property (
		$past(bus_req.rd) && $past(bus_req.addr) == 6'h08 |-> bus_rdata == 0)
		else $error("unmapped read");
	a_func_hold: assert property (
		(!bus_req.wr && $stable(remap_pin_n_in)) [*4] |=> $stable(func_in))
		else $error("input moved");
	a_out_hold: assert property (
		!$past(bus_req.wr) && $stable(periph_out) |=> $stable(remap_pin_n_out))
		else $error("output moved");
	a_drv_hold: assert property (!$past(bus_req.wr) |=>
		$stable(remap_pin_n_drive))
		else $error("enable moved");
	a_drv_null: assert property (s_pin0(5'h00) |=> remap_pin_n_drive[0])
		else $error("null pin driven");
	a_drv_sel: assert property (s_pin0(5'h01) |=> !remap_pin_n_drive[0] &&
		remap_pin_n_out[0] == $past(periph_out[0])) else $error("bad route");
endmodule
bind rpsel_top rpsel_chk #(.NUM_PINS(NUM_PINS),
	.NUM_OUT_FUNCS(NUM_OUT_FUNCS)) chk_u (.sys_clk(sys_clk),
	.resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
	.remap_pin_n_in(remap_pin_n_in), .remap_pin_n_out(remap_pin_n_out),
	.remap_pin_n_drive(remap_pin_n_drive), .func_in(func_in),
	.periph_out(periph_out));

// >>> tb/tb.sv
// Self-checking bench for the pin select crossbar
`timescale 1ns/1ps
module tb;
	logic sys_clk = 0, resetn = 0, hold = 1;
	rpsel_pkg::rpsel_req_t rq = '0;
	logic [15:0] rdata;
	logic [25:0] pins = '0, p_out, p_drv;
	logic [30:0] pv;
	rpsel_pkg::rpsel_func_in_t fin;
	logic [4:0] c0, c1;
	int fail_count = 0, n_tests = 0;
	always #2.5 sys_clk = ~sys_clk;
	rpsel_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .bus_req(rq),
		.bus_rdata(rdata), .remap_pin_n_in(pins), .remap_pin_n_out(p_out),
		.remap_pin_n_drive(p_drv), .func_in(fin), .periph_out(pv));
	rpsel_periph peer_u (.sys_clk(sys_clk), .hold(hold), .periph_out(pv));
	task automatic chk(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// One bus cycle; a read is checked in the slot after its strobe
	task automatic bus(input logic [5:0] a, logic [15:0] d, logic w);
		@(posedge sys_clk);
		rq <= '{a, d, w, !w};
		@(posedge sys_clk);
		rq <= '{a, d, 1'b0, 1'b0};
		#1 if (!w) chk(rdata, d);
	endtask
	// Codes 26 to 30 are skipped since they behave like 31
	function automatic logic [4:0] pick(input int r);
		return (r == 26) ? 5'h1F : 5'(r);
	endfunction
	function automatic logic want_in(input logic [4:0] c);
		return (c < 5'h1A) ? pins[c] : 1'b0;
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#50000 fail_count++;
		conclude;
	end
	initial begin
		void'($urandom(32'hA82C));
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		bus(6'h03, 16'h1F1F, 0);
		bus(6'h00, 16'hFFFF, 1);
		bus(6'h00, 16'h1F1F, 0);
		bus(6'h08, 16'hFFFF, 1);
		bus(6'h08, 16'h0000, 0);
		$display("register test done");
		for (int k = 0; k < 7; k++) begin
			c0 = (k == 0) ? 5'h1F : pick($urandom % 27);
			c1 = pick($urandom % 27);
			bus(6'(k), {3'h0, c1, 3'h0, c0}, 1);
			@(posedge sys_clk) pins <= 26'($urandom);
			repeat (5) @(posedge sys_clk);
			#1 chk(fin[13-2*k], want_in(c0));
			chk(fin[12-2*k], want_in(c1));
		end
		$display("input test done");
		hold <= 1'b0;
		bus(6'h10, 16'h0001, 1);
		for (int k = 0; k < 13; k++) begin
			c0 = (k == 0) ? 5'h00 : 5'($urandom);
			c1 = 5'($urandom);
			bus(6'h10 + 6'(k), {3'h0, c1, 3'h0, c0}, 1);
			hold <= 1'b1;
			repeat (3) @(posedge sys_clk);
			#1 chk(p_drv[2*k], c0 == 5'h00);
			if (c0 != 5'h00) chk(p_out[2*k], pv[c0-1]);
			chk(p_drv[2*k+1], c1 == 5'h00);
			if (c1 != 5'h00) chk(p_out[2*k+1], pv[c1-1]);
			hold <= 1'b0;
		end
		$display("output test done");
		conclude;
	end
endmodule
